// [core/fws_pkg.sv]
// constants, states and carrier types of the flash write and erase sequencer
// assumes a 50 MHz mclk and a 16-bit flash whose ready line marks each completion
package fws_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int MCLK_MHZ      = 50;
	localparam int ACC_NS        = 100;   // flash read access time
	localparam int WEP_NS        = 60;    // write strobe low time
	localparam int PRG_TYP_US    = 60;    // typical program time of one word
	localparam int ERS_TYP_MS    = 500;   // typical erase time of one sector
	localparam int ERS_MAX_MS    = 3500;  // longest erase time of one sector
	localparam int ACC_CYC       = (ACC_NS * MCLK_MHZ + 999) / 1000;
	localparam int WEP_CYC       = (WEP_NS * MCLK_MHZ + 999) / 1000;
	localparam int ERS_MAX_CYC   = ERS_MAX_MS * MCLK_MHZ * 1000;
	localparam int SYNC_LAT      = 2;     // extra cycles for the data synchroniser

	// ----------------------------------------------------------------
	// address space
	// ----------------------------------------------------------------
	localparam int          FA_W        = 24;            // flash word address pins
	localparam logic [31:0] FLASH_BASE  = 32'h4200_0000;
	localparam logic [31:0] FLASH_SPAN  = 32'h0200_0000; // 2 ** (FA_W + 1) bytes
	localparam logic [31:0] SECTOR_SIZE = 32'h0002_0000;
	localparam logic [31:0] WORD_STEP   = 32'h0000_0002;

	// ----------------------------------------------------------------
	// register map (byte offsets) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_POINTER = 8'h04;
	localparam logic [7:0] REG_QUEUE   = 8'h08;
	localparam logic [7:0] REG_RSTART  = 8'h0c;
	localparam logic [7:0] REG_RSIZE   = 8'h10;
	localparam logic [7:0] REG_COMMAND = 8'h14;
	localparam logic [7:0] REG_RADDR   = 8'h18;
	localparam logic [7:0] REG_RDATA   = 8'h1c;
	localparam int         CMD_PREP    = 0;
	localparam int         CMD_CLR     = 1;
	localparam int         CMD_INIT    = 2;
	localparam int         ST_WE       = 13;
	localparam int         ST_WP       = 14;
	localparam int         ST_SE       = 15;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [31:0] PTR_RST    = 32'h0000_0000;

	// ----------------------------------------------------------------
	// queue
	// ----------------------------------------------------------------
	localparam int QDEPTH = 32;
	localparam int QIDX_W = 5;

	typedef enum logic [3:0] {
		ENG_IDLE, ENG_PCHK, ENG_PRD, ENG_PWR, ENG_PWAIT, ENG_PVFY, ENG_HANG,
		ENG_ECHK, ENG_EWR, ENG_EWAIT, ENG_RD
	} fws_state_e;

	typedef struct packed {
		logic [FA_W-1:0] addr;    // word address
		logic [15:0]     dq;      // data driven out
		logic            dqOeN;   // low while the data pins are driven
		logic            weN;     // write strobe, active low
		logic            oeN;     // read enable, active low
		logic            ersSel;  // high: write strobe starts a sector erase
	} fws_flash_s;

endpackage

// [core/fws_sequencer.sv]
// flash write and erase sequencer: apb register slave, 32-word write queue and
// the engine that programs, erases and reads a 16-bit parallel flash.
// assumes mclk at 50 MHz, one clock domain, and that the flash raises its ready
// line (drainIrq) once per finished program or erase; pins are synchronised here.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module fws_sequencer #(
	parameter int ERS_CYC = fws_pkg::ERS_MAX_CYC
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	output fws_pkg::fws_flash_s      flash,
	input  wire logic [15:0]         flashDqIn,
	input  wire logic                drainIrq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	fws_pkg::fws_state_e         st_q;
	fws_pkg::fws_flash_s         fl_q;
	logic [27:0]                 cnt_q;
	logic [15:0]                 mem_q [fws_pkg::QDEPTH];
	logic [fws_pkg::QIDX_W-1:0]  wrIdx_q, rdIdx_q;
	logic [fws_pkg::QIDX_W:0]    fill_q;
	logic [31:0]                 ptr_q, rStart_q, rSize_q, rAddr_q, erCur_q;
	logic [15:0]                 rdData_q;
	logic                        we_q, wp_q, se_q;
	logic                        rdy_q, err_q, rdPend_q, prPend_q;
	logic [31:0]                 prdata_q;
	logic [15:0]                 dq1_q, dq2_q;
	logic                        irq1_q, irq2_q, irq3_q;
	logic                        acc, full, empty, push, pop, idleAll, drainEv;
	logic                        rdReq, erReq, ldPtr, erDone, clrAll, init;
	logic                        setWe, setSe, done, hit;
	logic [31:0]                 rdVal, erLast, erNext;
	logic [15:0]                 head, stat;

	function automatic logic inRange(input logic [31:0] a);
		inRange = (a >= fws_pkg::FLASH_BASE) &&
			(a < fws_pkg::FLASH_BASE + fws_pkg::FLASH_SPAN);
	endfunction

	function automatic logic [fws_pkg::FA_W-1:0] wordOf(input logic [31:0] a);
		logic [31:0] off;
		off = a - fws_pkg::FLASH_BASE;
		wordOf = off[fws_pkg::FA_W:1];
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// two stages on the ready line and data pins; edge taken from stage two against a third delay stage
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq1_q <= 1'b0;
			irq2_q <= 1'b0;
			irq3_q <= 1'b0;
			dq1_q  <= 16'h0000;
			dq2_q  <= 16'h0000;
		end else begin
			irq1_q <= drainIrq;
			irq2_q <= irq1_q;
			irq3_q <= irq2_q;
			dq1_q  <= flashDqIn;
			dq2_q  <= dq1_q;
		end
	end
	assign drainEv = irq2_q && !irq3_q;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign acc  = psel && penable && !rdy_q;
	assign hit  = (paddr[1:0] == 2'b00) && (paddr <= fws_pkg::REG_RDATA);
	assign push = acc && pwrite && (paddr == fws_pkg::REG_QUEUE) && !full;
	assign ldPtr = acc && pwrite && (paddr == fws_pkg::REG_POINTER) && idleAll;
	assign clrAll = acc && pwrite && (paddr == fws_pkg::REG_COMMAND) &&
		(pwdata[fws_pkg::CMD_CLR] || pwdata[fws_pkg::CMD_INIT]);
	assign init = acc && pwrite && (paddr == fws_pkg::REG_COMMAND) &&
		pwdata[fws_pkg::CMD_INIT];
	// read starts only at rest, else it would finish on stale data
	assign rdReq = acc && !pwrite && (paddr == fws_pkg::REG_RDATA) && !rdPend_q &&
		(st_q == fws_pkg::ENG_IDLE);
	assign erReq = acc && pwrite && (paddr == fws_pkg::REG_COMMAND) &&
		pwdata[fws_pkg::CMD_PREP] && !prPend_q && idleAll;
	assign idleAll = (st_q == fws_pkg::ENG_IDLE) && empty;

	// decide whether the access in progress may finish this cycle
	always_comb begin
		done = 1'b1;
		if (paddr == fws_pkg::REG_QUEUE && pwrite) begin
			done = !full;
		end else if (paddr == fws_pkg::REG_POINTER && pwrite) begin
			done = idleAll;
		end else if (paddr == fws_pkg::REG_COMMAND && pwrite && pwdata[fws_pkg::CMD_PREP]) begin
			done = prPend_q && (st_q == fws_pkg::ENG_IDLE);
		end else if (paddr == fws_pkg::REG_RDATA && !pwrite) begin
			done = rdPend_q && (st_q == fws_pkg::ENG_IDLE);
		end
	end

	// every view but read data readable at any time; read data waits for its flash read
	always_comb begin
		case (paddr)
			fws_pkg::REG_STATUS:  rdVal = {16'h0000, stat};
			fws_pkg::REG_POINTER: rdVal = ptr_q;
			fws_pkg::REG_QUEUE:   rdVal = {26'h0000000, fill_q};
			fws_pkg::REG_RSTART:  rdVal = rStart_q;
			fws_pkg::REG_RSIZE:   rdVal = rSize_q;
			fws_pkg::REG_RADDR:   rdVal = rAddr_q;
			fws_pkg::REG_RDATA:   rdVal = {16'h0000, rdData_q};
			default:              rdVal = 32'h0000_0000;
		endcase
	end

	// answer is registered, so every access sees at least one wait state
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdy_q    <= 1'b0;
			err_q    <= 1'b0;
			prdata_q <= 32'h0000_0000;
			rdPend_q <= 1'b0;
			prPend_q <= 1'b0;
		end else if (rdy_q) begin
			rdy_q <= 1'b0;
			err_q <= 1'b0;
		end else if (acc && (done || !hit)) begin
			rdy_q    <= 1'b1;
			err_q    <= !hit;
			prdata_q <= pwrite ? 32'h0000_0000 : rdVal;
			rdPend_q <= 1'b0;
			prPend_q <= 1'b0;
		end else begin
			if (rdReq)
				rdPend_q <= 1'b1;
			if (erReq)
				prPend_q <= 1'b1;
		end
	end
	assign prdata  = prdata_q;
	assign pready  = rdy_q;
	assign pslverr = err_q;

	// whole 32-bit byte addresses
	// plain software registers for range and read address
	always_ff @(posedge mclk) begin
		if (rst) begin
			rStart_q <= fws_pkg::FLASH_BASE;
			rSize_q  <= fws_pkg::SECTOR_SIZE;
			rAddr_q  <= fws_pkg::FLASH_BASE;
		end else if (acc && pwrite) begin
			if (paddr == fws_pkg::REG_RSTART)
				rStart_q <= pwdata;
			if (paddr == fws_pkg::REG_RSIZE)
				rSize_q <= pwdata;
			if (paddr == fws_pkg::REG_RADDR)
				rAddr_q <= pwdata;
		end
	end

	// ----------------------------------------------------------------
	// write queue
	// ----------------------------------------------------------------
	assign full  = fill_q == 6'(fws_pkg::QDEPTH);
	assign empty = fill_q == 6'h00;
	assign head  = mem_q[rdIdx_q];

	genvar gi;
	generate
		for (gi = 0; gi < fws_pkg::QDEPTH; gi++) begin : g_slot
			always_ff @(posedge mclk) begin
				if (rst)
					mem_q[gi] <= 16'h0000;
				else if (push && wrIdx_q == fws_pkg::QIDX_W'(gi))
					mem_q[gi] <= pwdata[15:0];
			end
		end
	endgenerate

	// push lands in the same access; initialise flushes the queue
	always_ff @(posedge mclk) begin
		if (rst || init) begin
			wrIdx_q <= 5'h00;
			rdIdx_q <= 5'h00;
			fill_q  <= 6'h00;
		end else begin
			if (push)
				wrIdx_q <= wrIdx_q + 5'h01;
			if (pop)
				rdIdx_q <= rdIdx_q + 5'h01;
			if (push && !pop)
				fill_q <= fill_q + 6'h01;
			else if (pop && !push)
				fill_q <= fill_q - 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// engine
	// ----------------------------------------------------------------
	assign erLast = rStart_q + rSize_q - 32'h0000_0001;
	assign erNext = erCur_q + fws_pkg::SECTOR_SIZE;
	assign erDone = (st_q == fws_pkg::ENG_EWAIT) && drainEv && (erNext > erLast);
	// finished or skipped word moves the queue on
	assign pop = ((st_q == fws_pkg::ENG_PVFY) && cnt_q == 28'h0) ||
		((st_q == fws_pkg::ENG_PCHK) && !inRange(ptr_q));
	// out of range, unerased or failed verify
	assign setWe = ((st_q == fws_pkg::ENG_PCHK) && !inRange(ptr_q)) ||
		((st_q == fws_pkg::ENG_PRD) && cnt_q == 28'h0 && |(head & ~dq2_q)) ||
		((st_q == fws_pkg::ENG_PVFY) && cnt_q == 28'h0 && dq2_q != head);
	assign setSe = ((st_q == fws_pkg::ENG_ECHK) && !inRange(erCur_q)) ||
		((st_q == fws_pkg::ENG_EWAIT) && !drainEv && cnt_q == 28'(ERS_CYC - 1));

	// state, timer, pins and captured data move together
	always_ff @(posedge mclk) begin
		if (rst || init) begin
			st_q     <= fws_pkg::ENG_IDLE;
			cnt_q    <= 28'h0;
			erCur_q  <= fws_pkg::FLASH_BASE;
			rdData_q <= 16'h0000;
			fl_q     <= '{addr: '0, dq: 16'h0000, dqOeN: 1'b1, weN: 1'b1, oeN: 1'b1,
				ersSel: 1'b0};
		end else begin
			case (st_q)
				fws_pkg::ENG_IDLE: begin
					fl_q.oeN <= 1'b1;
					cnt_q    <= 28'(fws_pkg::ACC_CYC + fws_pkg::SYNC_LAT);
					if (rdReq) begin
						// reads go ahead of queued words
						fl_q.addr <= wordOf(rAddr_q);
						fl_q.oeN  <= 1'b0;
						st_q      <= fws_pkg::ENG_RD;
					end else if (erReq) begin
						// start at the sector holding the range start
						erCur_q <= rStart_q & ~(fws_pkg::SECTOR_SIZE - 32'h0000_0001);
						st_q    <= fws_pkg::ENG_ECHK;
					end else if (!empty) begin
						st_q <= fws_pkg::ENG_PCHK;
					end
				end
				fws_pkg::ENG_RD: begin
					cnt_q <= cnt_q - 28'h1;
					if (cnt_q == 28'h0) begin
						rdData_q <= dq2_q;
						fl_q.oeN <= 1'b1;
						st_q     <= fws_pkg::ENG_IDLE;
					end
				end
				fws_pkg::ENG_PCHK: begin
					fl_q.addr <= wordOf(ptr_q);
					fl_q.oeN  <= !inRange(ptr_q);
					st_q      <= inRange(ptr_q) ? fws_pkg::ENG_PRD : fws_pkg::ENG_IDLE;
				end
				fws_pkg::ENG_PRD: begin
					cnt_q <= cnt_q - 28'h1;
					if (cnt_q == 28'h0) begin
						fl_q.oeN <= 1'b1;
						// a zero that must become one locks the engine
						if (|(head & ~dq2_q)) begin
							st_q <= fws_pkg::ENG_HANG;
						end else begin
							fl_q.dq    <= head;
							fl_q.dqOeN <= 1'b0;
							fl_q.weN   <= 1'b0;
							cnt_q      <= 28'(fws_pkg::WEP_CYC - 1);
							st_q       <= fws_pkg::ENG_PWR;
						end
					end
				end
				fws_pkg::ENG_PWR, fws_pkg::ENG_EWR: begin
					cnt_q <= cnt_q - 28'h1;
					if (cnt_q == 28'h0) begin
						fl_q.weN   <= 1'b1;
						fl_q.dqOeN <= 1'b1;
						fl_q.ersSel <= 1'b0;
						cnt_q      <= 28'h0;
						st_q       <= (st_q == fws_pkg::ENG_PWR) ? fws_pkg::ENG_PWAIT
							: fws_pkg::ENG_EWAIT;
					end
				end
				fws_pkg::ENG_PWAIT: begin
					// only the completion edge releases the word
					if (drainEv) begin
						fl_q.oeN <= 1'b0;
						cnt_q    <= 28'(fws_pkg::ACC_CYC + fws_pkg::SYNC_LAT);
						st_q     <= fws_pkg::ENG_PVFY;
					end
				end
				fws_pkg::ENG_PVFY: begin
					cnt_q <= cnt_q - 28'h1;
					if (cnt_q == 28'h0) begin
						fl_q.oeN <= 1'b1;
						st_q     <= fws_pkg::ENG_IDLE;
					end
				end
				fws_pkg::ENG_HANG: begin
					st_q <= fws_pkg::ENG_HANG; // left only by initialise or reset
				end
				fws_pkg::ENG_ECHK: begin
					if (!inRange(erCur_q)) begin
						st_q <= fws_pkg::ENG_IDLE;
					end else begin
						fl_q.addr   <= wordOf(erCur_q);
						fl_q.ersSel <= 1'b1;
						fl_q.weN    <= 1'b0;
						cnt_q       <= 28'(fws_pkg::WEP_CYC - 1);
						st_q        <= fws_pkg::ENG_EWR;
					end
				end
				fws_pkg::ENG_EWAIT: begin
					cnt_q <= cnt_q + 28'h1;
					if (drainEv) begin
						erCur_q <= erNext;
						st_q    <= (erNext > erLast) ? fws_pkg::ENG_IDLE : fws_pkg::ENG_ECHK;
					end else if (cnt_q == 28'(ERS_CYC - 1)) begin
						st_q <= fws_pkg::ENG_IDLE;
					end
				end
				default: st_q <= fws_pkg::ENG_IDLE;
			endcase
		end
	end
	assign flash = fl_q;

	// ----------------------------------------------------------------
	// write pointer
	// ----------------------------------------------------------------
	// loaded by host or by a finished erase, stepped by engine
	always_ff @(posedge mclk) begin
		if (rst)
			ptr_q <= fws_pkg::PTR_RST;
		else if (ldPtr)
			ptr_q <= pwdata;
		else if (erDone)
			ptr_q <= rStart_q;
		else if (pop)
			ptr_q <= ptr_q + fws_pkg::WORD_STEP; // moves only after the word is finished or skipped
	end

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	// sticky bits, a new fault wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			we_q <= fws_pkg::STATUS_RST[fws_pkg::ST_WE];
			se_q <= fws_pkg::STATUS_RST[fws_pkg::ST_SE];
		end else begin
			we_q <= setWe || (we_q && !clrAll);
			se_q <= setSe || (se_q && !clrAll);
		end
	end

	// busy from first push until queue empty and engine back at rest
	always_ff @(posedge mclk) begin
		if (rst)
			wp_q <= fws_pkg::STATUS_RST[fws_pkg::ST_WP];
		else if (push)
			wp_q <= 1'b1;
		else if (init || (empty && st_q == fws_pkg::ENG_IDLE))
			wp_q <= 1'b0;
	end
	assign stat = {se_q, wp_q, we_q, 13'h0000};

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_sticky;
		$past(we_q) && !$past(clrAll) |-> we_q;
	endproperty
	a_sticky: assert property (p_sticky) else $error("error bit dropped");

	property p_wpSet;
		push |=> wp_q [*2];
	endproperty
	a_wpSet: assert property (p_wpSet) else $error("busy flag not set");

	property p_fullStall;
		acc && pwrite && paddr == fws_pkg::REG_QUEUE && full |=> !pready;
	endproperty
	a_fullStall: assert property (p_fullStall) else $error("push taken while full");

	property p_pushFast;
		acc && pwrite && paddr == fws_pkg::REG_QUEUE && !full |=> pready && !pslverr;
	endproperty
	a_pushFast: assert property (p_pushFast) else $error("push not answered");

	property p_step;
		pop && !ldPtr |=> ptr_q == $past(ptr_q) + fws_pkg::WORD_STEP;
	endproperty
	a_step: assert property (p_step) else $error("pointer step wrong");

	property p_hang;
		st_q == fws_pkg::ENG_HANG && !init |=> st_q == fws_pkg::ENG_HANG && wp_q && !pop;
	endproperty
	a_hang: assert property (p_hang) else $error("hang left early");

	property p_ldWait;
		ldPtr |-> empty && st_q == fws_pkg::ENG_IDLE ##1 ptr_q == $past(pwdata) && !wp_q;
	endproperty
	a_ldWait: assert property (p_ldWait) else $error("pointer loaded while busy");

	property p_erWait;
		$rose(st_q == fws_pkg::ENG_ECHK) && $past(st_q) == fws_pkg::ENG_IDLE |-> empty;
	endproperty
	a_erWait: assert property (p_erWait) else $error("erase before queue empty");

	property p_seBad;
		st_q == fws_pkg::ENG_ECHK && !inRange(erCur_q) |=> se_q && st_q == fws_pkg::ENG_IDLE;
	endproperty
	a_seBad: assert property (p_seBad) else $error("bad sector not flagged");

	property p_ersBound;
		st_q == fws_pkg::ENG_EWAIT |-> cnt_q < 28'(ERS_CYC);
	endproperty
	a_ersBound: assert property (p_ersBound) else $error("erase overran limit");

	c_push:  cover property (push ##[1:40] pop);
	c_erase: cover property (erDone);
	c_hang:  cover property (st_q == fws_pkg::ENG_HANG);
	c_read:  cover property (st_q == fws_pkg::ENG_RD ##[1:20] pready);

endmodule
`default_nettype wire

// [bench/fws_flash_model.sv]
// behavioural 16-bit parallel flash seen on the sequencer's pins
// assumes the pin struct of the package and a ready line that pulses per job
`timescale 1ns/100ps
`default_nettype none

module fws_flash_model #(
	parameter int PRG_CYC = 20,
	parameter int ERS_CYC = 60
) (
	input  wire logic                mclk,
	input  wire fws_pkg::fws_flash_s flash,
	output logic      [15:0]         dqOut,
	output logic                     ready
);
	logic [15:0] mem [int];
	logic [15:0] capD;
	int          capA;
	logic        capE;
	logic        weWas;

	initial begin
		ready = 1'b0;
		dqOut = 16'h0000;
		weWas = 1'b1;
	end

	function automatic logic [15:0] peek(input int a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction

	// one job per strobe, finished by a ready pulse
	task automatic job(input int a, input logic [15:0] d, input logic e);
		if (e) begin
			foreach (mem[k]) if ((k >> 16) == (a >> 16)) mem[k] = 16'hffff;
			repeat (ERS_CYC) @(posedge mclk);
		end else begin
			mem[a] = peek(a) & d;
			repeat (PRG_CYC) @(posedge mclk);
		end
		ready <= 1'b1;
		repeat (4) @(posedge mclk);
		ready <= 1'b0;
	endtask

	// strobe values are captured while low, since the sequencer may move them at release
	always @(posedge mclk) begin
		if (flash.weN === 1'b0) begin
			capA <= int'(flash.addr);
			// undriven data pins read as zero, so a missing drive fails verify
			capD <= (flash.dqOeN === 1'b0) ? flash.dq : 16'h0000;
			capE <= flash.ersSel;
		end
		if (weWas === 1'b0 && flash.weN === 1'b1)
			fork
				job(capA, capD, capE);
			join_none
		weWas <= flash.weN;
		// released pins toggle so a stale word is never mistaken for data
		dqOut <= !flash.oeN ? peek(int'(flash.addr)) : ~dqOut;
	end
endmodule
`default_nettype wire

// [bench/fws_sequencer_test.sv]
// self-checking bench of the sequencer, apb master plus flash model
// assumes a shortened erase timeout so the run stays brief
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end

module fws_sequencer_test;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} fws_row_s;
	localparam logic [7:0] ST = 8'h00, PT = 8'h04, QU = 8'h08, RS = 8'h0c, RZ = 8'h10;
	localparam logic [7:0] CM = 8'h14, RA = 8'h18, RD = 8'h1c;
	logic                mclk, rst, psel, penable, pwrite, pready, pslverr, drainIrq, got, er;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata, rd;
	logic [15:0]         flashDqIn;
	fws_pkg::fws_flash_s flash;
	fws_row_s            rows [9];
	int                  fails, n_tests;

	fws_sequencer #(.ERS_CYC(200)) dut_u (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .flash(flash),
		.flashDqIn(flashDqIn), .drainIrq(drainIrq));
	fws_flash_model flash_u (.mclk(mclk), .flash(flash), .dqOut(flashDqIn), .ready(drainIrq));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ---
	// apb master: request held until pready is sampled or lim cycles pass
	// ---
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input int lim);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		got = 1'b0;
		while (!got && n < lim) begin
			@(posedge mclk);
			n++;
			got = (pready === 1'b1);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb(w, a, d, 3000);
		if (!got) begin
			fails++;
			$display("unexpected t=%0t got %h exp %h", $time, 1'b0, 1'b1);
			tally_and_finish();
		end
	endtask

	// poll status until the program flag drops, bounded
	task automatic idle();
		for (int i = 0; i < 100; i++) begin
			acc(0, ST, 0);
			if (rd[14] === 1'b0) break;
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ---
	// main sequence
	// ---
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fails = 0;
		n_tests = 0;
		rows = '{'{0, ST, 0, 0, 0}, '{0, PT, 0, 0, 0}, '{0, QU, 0, 0, 0},
			'{0, RS, 0, 32'h4200_0000, 0}, '{0, RZ, 0, 32'h2_0000, 0},
			'{0, RA, 0, 32'h4200_0000, 0}, '{1, RZ, 32'h40, 0, 0},
			'{0, RZ, 0, 32'h40, 0}, '{0, 8'h20, 0, 0, 1}};
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			acc(rows[i].w, rows[i].a, rows[i].d);
			`CHK(er, rows[i].er)
			if (!rows[i].w && !rows[i].er) `CHK(rd, rows[i].e)
		end
		$display("register table done");
		acc(1, RS, 32'h4200_0010);
		acc(1, RZ, 32'h4);
		acc(1, CM, 32'h1);
		acc(0, PT, 0);
		`CHK(rd, 32'h4200_0010)
		// pointer loaded by the prepare before the first push
		acc(1, QU, 32'h1234);
		acc(0, ST, 0);
		`CHK(rd, 32'h4000)
		acc(1, QU, 32'h0f0f);
		acc(1, QU, 32'h00ff);
		idle();
		`CHK(rd, 32'h0)
		acc(0, PT, 0);
		`CHK(rd, 32'h4200_0016)
		// a read issued while a word is in flight waits for it, then reads
		acc(1, RA, 32'h4200_0012);
		acc(1, QU, 32'h0ff0);
		acc(0, RD, 0);
		`CHK(rd[15:0], 16'h0f0f)
		// a pointer load waits until the queued word has finished
		acc(1, QU, 32'h0ff1);
		acc(1, PT, 32'h4200_0020);
		acc(0, ST, 0);
		`CHK(rd, 32'h0)
		acc(0, PT, 0);
		`CHK(rd, 32'h4200_0020)
		$display("prepare and program done");
		acc(1, PT, 32'h4000_0000);
		acc(1, QU, 32'h5555);
		idle();
		`CHK(rd, 32'h2000)
		acc(0, PT, 0);
		`CHK(rd, 32'h4000_0002)
		acc(1, CM, 32'h2);
		acc(0, ST, 0);
		`CHK(rd, 32'h0)
		acc(1, RS, 32'h4100_0000);
		acc(1, CM, 32'h1);
		acc(0, ST, 0);
		`CHK(rd, 32'h8000)
		acc(1, CM, 32'h4);
		acc(0, ST, 0);
		`CHK(rd, 32'h0)
		$display("fault flags done");
		// a word needing a zero back to one locks the queue and flags a fault
		acc(1, PT, 32'h4200_0010);
		for (int i = 0; i < 32; i++) acc(1, QU, 32'hffff);
		acc(0, QU, 0);
		`CHK(rd, 32'd32)
		acc(0, ST, 0);
		`CHK(rd, 32'h6000)
		apb(1, QU, 32'h1, 200);
		`CHK(got, 1'b0)
		rst <= 1'b1;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		acc(0, QU, 0);
		`CHK(rd, 32'h0)
		acc(0, ST, 0);
		`CHK(rd, 32'h0)
		$display("hang and stall done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
